// *** core/uart_extra_features.sv ***
`timescale 1ns/1ps
`include "uart_efc_params.svh"

module uart_extra_features (
  input  wire logic                    clk_in,            // Core clock
  input  wire logic                    rst_n_in,          // Sync reset
  input  wire uart_efc_pkg::axil_req_s axi_in,            // Bus requests
  output uart_efc_pkg::axil_rsp_s      axi_out,           // Bus answers
  input  wire logic                    tx_fifo_wr_in,     // Host FIFO write
  input  wire logic                    tx_fifo_empty_in,  // FIFO empty
  input  wire logic                    tx_shift_busy_in,  // Char shifting
  input  wire logic                    tx_serial_in,      // Core serial out
  output logic                         tx_load_en_out,    // May load shifter
  output logic                         txd_out,           // Transmit pin
  input  wire logic                    rxd_in,            // Receive pin
  output logic                         rx_serial_out,     // To receiver
  output logic                         rx_en_out,         // Receiver on
  output logic                         rx_flush_out,      // Push held char
  input  wire logic                    rx_char_valid_in,  // Char received
  input  wire logic                    rx_parity_in,      // Its parity bit
  output logic                         addr_evt_out,      // Address event
  input  wire uart_efc_pkg::rts_src_s  rts_src_in,        // Pin sources
  output logic                         rts_n_out,         // Direction pin
  output logic                         irda_quarter_out,  // IR pulse select
  output logic                         multidrop_out      // Nine-bit mode
);
  import uart_efc_pkg::*;

  efc_state_s st_r;
  efc_state_s st_nxt;
  logic       sending;
  logic       rts_level;
  logic       wr_go;
  logic [7:0] ctrl_wr;
  logic [7:0] status;

  // Transmitter holds data: write now, FIFO or shifter busy
  assign sending = tx_fifo_wr_in | !tx_fifo_empty_in
                 | tx_shift_busy_in;

  // Direction pin source chooser
  rts_direction u_rts (
    .auto_en_in (st_r.ctrl[`EFC_AUTO_BIT]),
    .invert_in  (st_r.ctrl[`EFC_INV_BIT]),
    .sending_in (sending),
    .src_in     (rts_src_in),
    .rts_n_out  (rts_level)
  );

  // Status word seen by software
  always_comb begin
    status                   = 8'h00;
    status[`EFC_ST_TXOFF]    = (st_r.tx_state == TX_OFF);
    status[`EFC_ST_DRAIN]    = (st_r.tx_state == TX_DRAIN);
    status[`EFC_ST_RTS]      = st_r.rts_n;
    status[`EFC_ST_ADDR]     = st_r.addr_seen;
    status[`EFC_ST_SENDING]  = sending;
  end

  // A write completes once address and data are both held
  assign wr_go   = st_r.aw_held && st_r.w_held && !st_r.rsp.bvalid;
  assign ctrl_wr = st_r.w_byte & `EFC_CTRL_MASK;

  // Next-state logic for the whole block
  always_comb begin
    st_nxt = st_r;
    st_nxt.rx_flush = 1'b0;
    st_nxt.addr_evt = 1'b0;

    // Write address and data capture, any order
    if (axi_in.awvalid && st_r.rsp.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = axi_in.awaddr;
    end
    if (axi_in.wvalid && st_r.rsp.wready) begin
      st_nxt.w_held  = 1'b1;
      st_nxt.w_byte  = axi_in.wdata[7:0];
      st_nxt.w_lane0 = axi_in.wstrb[0];
    end

    // Write commit and response
    if (wr_go) begin
      st_nxt.aw_held   = 1'b0;
      st_nxt.w_held    = 1'b0;
      st_nxt.rsp.bvalid = 1'b1;
      if (st_r.aw_addr == `EFC_ADDR_CTRL) begin
        st_nxt.rsp.bresp = `EFC_RESP_OKAY;
        if (st_r.w_lane0) begin
          st_nxt.ctrl = ctrl_wr;
        end
      end else if (st_r.aw_addr == `EFC_ADDR_STATUS) begin
        st_nxt.rsp.bresp = `EFC_RESP_OKAY;
        if (st_r.w_lane0 && st_r.w_byte[`EFC_ST_ADDR]) begin
          st_nxt.addr_seen = 1'b0;
        end
      end else begin
        st_nxt.rsp.bresp = `EFC_RESP_DECERR;
      end
    end else if (st_r.rsp.bvalid && axi_in.bready) begin
      st_nxt.rsp.bvalid = 1'b0;
    end
    st_nxt.rsp.awready = !st_nxt.aw_held && !st_nxt.rsp.bvalid;
    st_nxt.rsp.wready  = !st_nxt.w_held && !st_nxt.rsp.bvalid;

    // Read channel, one cycle answer
    if (axi_in.arvalid && st_r.rsp.arready) begin
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rdata  = 32'h0000_0000;
      st_nxt.rsp.rresp  = `EFC_RESP_OKAY;
      if (axi_in.araddr == `EFC_ADDR_CTRL) begin
        st_nxt.rsp.rdata[7:0] = st_r.ctrl;
      end else if (axi_in.araddr == `EFC_ADDR_STATUS) begin
        st_nxt.rsp.rdata[7:0] = status;
      end else begin
        st_nxt.rsp.rresp = `EFC_RESP_DECERR;
      end
    end else if (st_r.rsp.rvalid && axi_in.rready) begin
      st_nxt.rsp.rvalid = 1'b0;
    end
    st_nxt.rsp.arready = !st_nxt.rsp.rvalid;

    // Transmitter disable sequence
    case (st_r.tx_state)
      TX_RUN: begin
        if (st_r.ctrl[`EFC_TXOFF_BIT]) begin
          st_nxt.tx_state = TX_DRAIN;
        end
      end
      TX_DRAIN: begin
        if (!st_r.ctrl[`EFC_TXOFF_BIT]) begin
          st_nxt.tx_state = TX_RUN;
        end else if (!tx_shift_busy_in) begin
          st_nxt.tx_state = TX_OFF;
        end
      end
      TX_OFF: begin
        if (!st_r.ctrl[`EFC_TXOFF_BIT]) begin
          st_nxt.tx_state = TX_RUN;
        end
      end
      default: begin
        st_nxt.tx_state = TX_RUN;
      end
    endcase
    // No new loads once disable is requested; FIFO writes stay open
    st_nxt.tx_load_en = (st_nxt.tx_state == TX_RUN);
    st_nxt.txd = (st_nxt.tx_state == TX_OFF) ? 1'b1
               : tx_serial_in;

    // Direction pin
    st_nxt.rts_n = rts_level;

    // Receive pin synchroniser and gating
    st_nxt.rxd_meta  = rxd_in;
    st_nxt.rxd_sync  = st_r.rxd_meta;
    st_nxt.rx_en     = !st_nxt.ctrl[`EFC_RXOFF_BIT];
    st_nxt.rx_serial = st_nxt.rx_en ? st_r.rxd_sync : 1'b1;
    st_nxt.rx_flush  = st_nxt.ctrl[`EFC_RXOFF_BIT]
                     && !st_r.ctrl[`EFC_RXOFF_BIT];

    // Multidrop address detection, set beats clear
    if (st_r.ctrl[`EFC_MDROP_BIT] && rx_char_valid_in
        && rx_parity_in) begin
      st_nxt.addr_evt  = 1'b1;
      st_nxt.addr_seen = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r                 <= '0;
      st_r.rsp.awready     <= 1'b1;
      st_r.rsp.wready      <= 1'b1;
      st_r.rsp.arready     <= 1'b1;
      st_r.ctrl            <= `EFC_CTRL_RST;
      st_r.tx_state        <= TX_RUN;
      st_r.tx_load_en      <= 1'b1;
      st_r.txd             <= 1'b1;
      st_r.rts_n           <= 1'b1;
      st_r.rxd_meta        <= 1'b1;
      st_r.rxd_sync        <= 1'b1;
      st_r.rx_serial       <= 1'b1;
      st_r.rx_en           <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign axi_out          = st_r.rsp;
  assign tx_load_en_out   = st_r.tx_load_en;
  assign txd_out          = st_r.txd;
  assign rx_serial_out    = st_r.rx_serial;
  assign rx_en_out        = st_r.rx_en;
  assign rx_flush_out     = st_r.rx_flush;
  assign addr_evt_out     = st_r.addr_evt;
  assign rts_n_out        = st_r.rts_n;
  assign irda_quarter_out = st_r.ctrl[`EFC_IRDA_BIT];
  assign multidrop_out    = st_r.ctrl[`EFC_MDROP_BIT];

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic ctrl_wr_ev;
  assign ctrl_wr_ev = wr_go && st_r.w_lane0
                   && (st_r.aw_addr == `EFC_ADDR_CTRL);

  irda_select_a: assert property (
    ctrl_wr_ev |=> irda_quarter_out == $past(st_r.w_byte[7]))
    else $error("IR pulse select did not follow write");

  multidrop_sel_a: assert property (
    ctrl_wr_ev |=> multidrop_out == $past(st_r.w_byte[0]))
    else $error("Multidrop select did not follow write");

  reserved_zero_a: assert property (
    ctrl_wr_ev |=> !st_r.ctrl[6] && !st_r.ctrl[3])
    else $error("Reserved control bit stored");

  rts_send_low_a: assert property (
    (st_r.ctrl[4] && !st_r.ctrl[5] && tx_shift_busy_in)
    |=> !rts_n_out)
    else $error("Direction pin not low while sending");

  rts_invert_a: assert property (
    (st_r.ctrl[4] && st_r.ctrl[5] && tx_shift_busy_in)
    |=> rts_n_out)
    else $error("Inverted direction pin not high");

  rts_on_write_a: assert property (
    (st_r.ctrl[4] && !st_r.ctrl[5] && tx_fifo_wr_in)
    |=> !rts_n_out)
    else $error("Direction pin late after FIFO write");

  rts_release_a: assert property (
    (st_r.ctrl[4] && !st_r.ctrl[5] && !sending) |=> rts_n_out)
    else $error("Direction pin not released when idle");

  rts_manual_a: assert property (
    (!st_r.ctrl[4] && !rts_src_in.flow_en)
    |=> rts_n_out == !$past(rts_src_in.mcr_rts))
    else $error("Direction pin ignores modem bit");

  rts_flow_a: assert property (
    (!st_r.ctrl[4] && rts_src_in.flow_en)
    |=> rts_n_out == $past(rts_src_in.flow_rts_n))
    else $error("Direction pin ignores flow control");

  tx_quiet_a: assert property (
    (st_r.tx_state == TX_OFF) |-> txd_out && !tx_load_en_out)
    else $error("Transmit pin active while off");

  tx_drain_a: assert property (
    (st_r.tx_state == TX_DRAIN && tx_shift_busy_in)
    |=> txd_out == $past(tx_serial_in))
    else $error("Character cut short by transmit off");

  rx_flush_a: assert property (
    $rose(st_r.ctrl[1]) |-> rx_flush_out && !rx_en_out
    ##1 !rx_flush_out)
    else $error("Receive off did not flush once");

  addr_event_a: assert property (
    (rx_char_valid_in && rx_parity_in)
    |=> addr_evt_out == $past(st_r.ctrl[0]))
    else $error("Address event wrong for mode");

  drain_done_c: cover property (
    st_r.tx_state == TX_DRAIN ##1 st_r.tx_state == TX_OFF);
  addr_seen_c: cover property (addr_evt_out);
  rts_cycle_c: cover property (
    st_r.ctrl[4] && !rts_n_out ##[1:50] rts_n_out);
  rx_flush_c: cover property (rx_flush_out);

endmodule : uart_extra_features

// *** inc/uart_efc_params.svh ***
`ifndef UART_EFC_PARAMS_SVH
`define UART_EFC_PARAMS_SVH

// Register byte addresses
`define EFC_ADDR_CTRL   4'h0
`define EFC_ADDR_STATUS 4'h4

// Control field positions
`define EFC_IRDA_BIT    7
`define EFC_INV_BIT     5
`define EFC_AUTO_BIT    4
`define EFC_TXOFF_BIT   2
`define EFC_RXOFF_BIT   1
`define EFC_MDROP_BIT   0

// Control reset value and writable mask
`define EFC_CTRL_RST    8'h00
`define EFC_CTRL_MASK   8'hB7

// Status field positions
`define EFC_ST_TXOFF    0
`define EFC_ST_DRAIN    1
`define EFC_ST_RTS      2
`define EFC_ST_ADDR     3
`define EFC_ST_SENDING  4

// Bus responses
`define EFC_RESP_OKAY   2'h0
`define EFC_RESP_DECERR 2'h3

`endif

// *** inc/uart_efc_pkg.sv ***
package uart_efc_pkg;

  // Transmitter enable states
  typedef enum logic [1:0] {
    TX_RUN,
    TX_DRAIN,
    TX_OFF
  } tx_state_e;

  // Master-driven AXI4-Lite signals
  typedef struct packed {
    logic        awvalid;
    logic [3:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [3:0]  araddr;
    logic        rready;
  } axil_req_s;

  // Slave-driven AXI4-Lite signals
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_s;

  // Sources of the direction pin outside auto mode
  typedef struct packed {
    logic mcr_rts;
    logic flow_en;
    logic flow_rts_n;
  } rts_src_s;

  // Whole state of the control block
  typedef struct packed {
    axil_rsp_s  rsp;
    logic       aw_held;
    logic [3:0] aw_addr;
    logic       w_held;
    logic [7:0] w_byte;
    logic       w_lane0;
    logic [7:0] ctrl;
    tx_state_e  tx_state;
    logic       tx_load_en;
    logic       txd;
    logic       rts_n;
    logic       rxd_meta;
    logic       rxd_sync;
    logic       rx_serial;
    logic       rx_en;
    logic       rx_flush;
    logic       addr_evt;
    logic       addr_seen;
  } efc_state_s;

endpackage : uart_efc_pkg

// *** core/rts_direction.sv ***
`timescale 1ns/1ps
`include "uart_efc_params.svh"

module rts_direction (
  input  wire logic                   auto_en_in,   // Auto direction on
  input  wire logic                   invert_in,    // Polarity swap
  input  wire logic                   sending_in,   // Transmitter has data
  input  wire uart_efc_pkg::rts_src_s src_in,       // Manual and flow sources
  output logic                        rts_n_out     // Next pin level
);
  import uart_efc_pkg::*;

  // Pin source selection, auto mode first
  always_comb begin
    if (auto_en_in) begin
      rts_n_out = invert_in ? sending_in : !sending_in;
    end else if (src_in.flow_en) begin
      rts_n_out = src_in.flow_rts_n;
    end else begin
      rts_n_out = !src_in.mcr_rts;
    end
  end

endmodule : rts_direction

// *** tb/line_xcvr_model.sv ***
`timescale 1ns/1ps

module line_xcvr_model (
  input  wire logic drv_on_in,   // Local driver enabled
  input  wire logic txd_in,      // Data onto the pair
  input  wire logic far_drv_in,  // Remote node drives the pair
  input  wire logic far_bit_in,  // Remote level
  output logic      rxd_out      // Receiver output
);
  // Own driver echoes back; undriven pair sits at mark by bias
  always_comb begin
    if (drv_on_in) begin
      rxd_out = txd_in;
    end else if (far_drv_in) begin
      rxd_out = far_bit_in;
    end else begin
      rxd_out = 1'b1;
    end
  end
endmodule : line_xcvr_model

// *** tb/tb_uart_extra_features_rs485_dir.sv ***
`timescale 1ns/1ps
`include "uart_efc_params.svh"

module tb_uart_extra_features_rs485_dir;
  import uart_efc_pkg::*;
  logic        clk_in   = 1'b0;
  logic        rst_n_in = 1'b0;
  axil_req_s   axi;
  axil_rsp_s   axo;
  rts_src_s    src;
  logic        fwr, fempty, busy, tser, rxd, cval, cpar;
  logic        far_drv, far_bit, auto_on, inv;
  logic        load_en, txd, rxs, rxen, flush, aevt, rts_n, irq4, mdrop;
  int          bad_count   = 0;
  int          checks_done = 0;
  int          flush_n     = 0;
  int          addr_n      = 0;
  logic [31:0] d, v;
  logic [1:0]  r;

  uart_extra_features u_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .axi_in(axi), .axi_out(axo),
    .tx_fifo_wr_in(fwr), .tx_fifo_empty_in(fempty),
    .tx_shift_busy_in(busy), .tx_serial_in(tser), .tx_load_en_out(load_en),
    .txd_out(txd), .rxd_in(rxd), .rx_serial_out(rxs), .rx_en_out(rxen),
    .rx_flush_out(flush), .rx_char_valid_in(cval), .rx_parity_in(cpar),
    .addr_evt_out(aevt), .rts_src_in(src), .rts_n_out(rts_n),
    .irda_quarter_out(irq4), .multidrop_out(mdrop));

  line_xcvr_model u_line (
    .drv_on_in(auto_on && (rts_n == inv)), .txd_in(txd),
    .far_drv_in(far_drv), .far_bit_in(far_bit), .rxd_out(rxd));

  // Clock
  always #20 clk_in = ~clk_in;

  // Count one-cycle pulses
  always @(posedge clk_in) begin
    if (flush === 1'b1) flush_n++;
    if (aevt === 1'b1) addr_n++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic settle;
    @(posedge clk_in);
    #1;
  endtask : settle

  // Bus write, both channels offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] dv,
                    output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk_in);
    axi.awvalid <= 1'b1;
    axi.awaddr  <= a;
    axi.wvalid  <= 1'b1;
    axi.wdata   <= dv;
    axi.wstrb   <= 4'hF;
    axi.bready  <= 1'b1;
    do begin
      @(posedge clk_in);
      if (axo.awready) axi.awvalid <= 1'b0;
      if (axo.wready) axi.wvalid <= 1'b0;
      n++;
    end while (axo.bvalid !== 1'b1 && n < 100);
    axi.bready <= 1'b0;
    rs = axo.bresp;
    if (n >= 100) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : wr

  // Bus read
  task automatic rd(input logic [3:0] a, output logic [31:0] dv,
                    output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk_in);
    axi.arvalid <= 1'b1;
    axi.araddr  <= a;
    axi.rready  <= 1'b1;
    do begin
      @(posedge clk_in);
      if (axo.arready) axi.arvalid <= 1'b0;
      n++;
    end while (axo.rvalid !== 1'b1 && n < 100);
    axi.rready <= 1'b0;
    dv = axo.rdata;
    rs = axo.rresp;
    if (n >= 100) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : rd

  // Main sequence
  initial begin
    axi = '0;
    src = '0;
    {fwr, busy, cval, cpar, far_drv, auto_on, inv} = 7'h00;
    {fempty, tser, far_bit} = 3'h7;
    v = $urandom(14043);
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(`EFC_ADDR_CTRL, d, r);
    chk("ctrl_reset", d, 32'h0);
    chk("rts_reset", rts_n, 1'b1);
    chk("txd_reset", txd, 1'b1);
    // Control writes with reserved bits set
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 32'hFF : $urandom;
      v = v & 32'hFFFF_FFE9;
      wr(`EFC_ADDR_CTRL, v, r);
      rd(`EFC_ADDR_CTRL, d, r);
      chk("ctrl_rd", d, v & 32'hB7);
      chk("irda_sel", irq4, v[7]);
      chk("multidrop", mdrop, v[0]);
    end
    wr(`EFC_ADDR_CTRL, 32'h0, r);
    wr(4'hC, 32'hFF, r);
    chk("wr_decerr", r, `EFC_RESP_DECERR);
    rd(4'h8, d, r);
    chk("rd_decerr", r, `EFC_RESP_DECERR);
    rd(`EFC_ADDR_CTRL, d, r);
    chk("ctrl_kept", d, 32'h0);
    // Manual sources while FIFO level varies
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      src    <= rts_src_s'($urandom);
      fempty <= 1'($urandom);
      settle();
      chk("rts_man", rts_n, src.flow_en ? src.flow_rts_n : !src.mcr_rts);
    end
    // Auto direction in both polarities
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_in);
      src     <= '{mcr_rts: 1'b1, flow_en: 1'b0, flow_rts_n: 1'b0};
      fempty  <= 1'b1;
      inv     <= p[0];
      auto_on <= 1'b1;
      wr(`EFC_ADDR_CTRL, p ? 32'h30 : 32'h10, r);
      settle();
      chk("rts_idle", rts_n, !p[0]);
      @(posedge clk_in);
      fwr <= 1'b1;
      @(posedge clk_in);
      fwr    <= 1'b0;
      fempty <= 1'b0;
      busy   <= 1'b1;
      tser   <= 1'b0;
      #1 chk("rts_write", rts_n, p[0]);
      settle();
      chk("txd_follow", txd, 1'b0);
      @(posedge clk_in);
      fempty <= 1'b1;
      tser   <= 1'b1;
      repeat (3) settle();
      chk("rts_busy", rts_n, p[0]);
      @(posedge clk_in);
      busy <= 1'b0;
      settle();
      chk("rts_done", rts_n, !p[0]);
    end
    // Transmit off while a character is shifting
    @(posedge clk_in);
    auto_on <= 1'b0;
    busy    <= 1'b1;
    tser    <= 1'b0;
    wr(`EFC_ADDR_CTRL, 32'h04, r);
    settle();
    chk("load_block", load_en, 1'b0);
    chk("txd_drain", txd, 1'b0);
    @(posedge clk_in);
    busy <= 1'b0;
    repeat (2) settle();
    chk("txd_off", txd, 1'b1);
    rd(`EFC_ADDR_STATUS, d, r);
    chk("st_off", d[0], 1'b1);
    wr(`EFC_ADDR_CTRL, 32'h0, r);
    // Receive off from an idle line
    @(posedge clk_in);
    tser    <= 1'b1;
    far_drv <= 1'b1;
    far_bit <= 1'b0;
    repeat (4) settle();
    chk("rx_on", rxs, 1'b0);
    @(posedge clk_in);
    far_bit <= 1'b1;
    repeat (4) settle();
    flush_n = 0;
    wr(`EFC_ADDR_CTRL, 32'h02, r);
    settle();
    chk("flush_once", flush_n, 1);
    chk("rx_dis", rxen, 1'b0);
    @(posedge clk_in);
    far_bit <= 1'b0;
    repeat (4) settle();
    chk("rx_quiet", rxs, 1'b1);
    // Address characters in each mode and parity
    for (int k = 0; k < 4; k++) begin
      wr(`EFC_ADDR_CTRL, (k > 1) ? 32'h01 : 32'h00, r);
      addr_n = 0;
      @(posedge clk_in);
      cval <= 1'b1;
      cpar <= k[0];
      @(posedge clk_in);
      cval <= 1'b0;
      repeat (2) settle();
      chk("addr_evt", addr_n, (k == 3) ? 1 : 0);
    end
    tally_and_finish();
  end

  // Watchdog
  initial begin
    #(40 * 20000);
    bad_count++;
    tally_and_finish();
  end
endmodule : tb_uart_extra_features_rs485_dir
